// file: crt_defines.svh
// register offsets, field positions and reset values of the timer 2/3 block
// assumes an 8-bit register port with a 3-bit address
`ifndef CRT_DEFINES_SVH
`define CRT_DEFINES_SVH

// register offsets
`define CRT_ADDR_MODE 3'h0
`define CRT_ADDR_T2 3'h1
`define CRT_ADDR_T3 3'h2
`define CRT_ADDR_STAT 3'h3
`define CRT_ADDR_CLR 3'h4
`define CRT_ADDR_EN 3'h5

// fields of shared_timer_mode_reg
`define CRT_BIT_OUT_SRC 0
`define CRT_BIT_T2_SRC 3
`define CRT_BIT_T3_SRC 4
`define CRT_BIT_POL 5
`define CRT_BIT_OUT_EN 6
`define CRT_BIT_LATCH_ONLY 7

// fields of the interrupt status, clear and enable registers
`define CRT_IRQ_T2 0
`define CRT_IRQ_T3 1

// reset values
`define CRT_MODE_RST 8'h00
`define CRT_CNT_RST 8'hFF
`define CRT_IRQ_RST 2'h0
`define CRT_ZERO8 8'h00
`define CRT_LVL_RST 1'b1

// divide-by-8 prescaler for the third timer
`define CRT_PRE_LAST 3'h7
`define CRT_PRE_RST 3'h0

`endif

// file: crt_pkg.sv
// types of the timer 2/3 block
// assumes crt_defines.svh is compiled alongside
package crt_pkg;

  typedef logic [7:0] crt_byte_t;
  typedef logic [2:0] crt_addr_t;
  typedef logic [1:0] crt_irq_t;

  // complete state of the block, registered in one process
  typedef struct packed {
    crt_byte_t mode;
    crt_byte_t t2_cnt;
    crt_byte_t t2_lat;
    crt_byte_t t3_cnt;
    crt_byte_t t3_lat;
    logic [2:0] pre;
    crt_irq_t stat;
    crt_irq_t en;
    logic pulse_lvl;
    logic pin;
    logic pin_oe;
    logic irq;
    logic t2_uf;
    logic t3_uf;
    crt_byte_t rdata;
  } crt_state_t;

endpackage

// file: crt_timers.sv
// timers two and three: cascaded 8-bit reload down counters with pulse output
// assumes a synchronous register port and a one-cycle timer 1 underflow pulse
//
// Contract
// - timer two is 8-bit counter with latch
// - write-control one: write reaches latch only
// - write-control zero: write loads counter and latch
// - write-control bit resets to zero
// - source change leaves timer two latch intact
// - timer two counts timer1 underflows or clock
// - underflow sets request, reloads, keeps counting
// - pulse mode needs enable and source one
// - pulse mode underflow toggles pin, sets request
// - pulse starts high at polarity zero
// - timer three is 8-bit counter with latch
// - timer three counts timer1 underflows or clock/8
// - timer three write always loads both
// - pin driven only when enabled, source selected
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "crt_defines.svh"

module crt_timers
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire crt_pkg::crt_addr_t reg_addr,
  input wire crt_pkg::crt_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // timer 1 side
  input wire logic t1_underflow,
  input wire logic t1_out_level,
  // timer output pin
  output logic timer_pulse_pin,
  output logic timer_pulse_pin_oe,
  // events
  output logic t2_underflow,
  output logic t3_underflow,
  output logic irq
);

  import crt_pkg::*;

  crt_state_t s_q;
  crt_state_t s_d;

  // one step of a reload down counter: {underflow, next count}
  function automatic logic [8:0] crt_step(input crt_byte_t cnt, input crt_byte_t lat, input logic tick);
    logic [8:0] r;
    r = {1'b0, cnt};
    if (tick)
    begin
      if (cnt == `CRT_ZERO8)
        r = {1'b1, lat};
      else
        r = {1'b0, cnt - 8'h01};
    end
    return r;
  endfunction

  logic wr_mode;
  logic wr_t2;
  logic wr_t3;
  logic wr_clr;
  logic wr_en;
  logic latch_only;
  logic t2_tick;
  logic t3_tick;
  logic pre_tick;
  logic pulse_mode;
  logic [8:0] t2_nx;
  logic [8:0] t3_nx;

  // address decode of the write strobe
  assign wr_mode = reg_wr && (reg_addr == `CRT_ADDR_MODE);
  assign wr_t2 = reg_wr && (reg_addr == `CRT_ADDR_T2);
  assign wr_t3 = reg_wr && (reg_addr == `CRT_ADDR_T3);
  assign wr_clr = reg_wr && (reg_addr == `CRT_ADDR_CLR);
  assign wr_en = reg_wr && (reg_addr == `CRT_ADDR_EN);

  // count sources and mode decode from the mode register in force
  assign latch_only = s_q.mode[`CRT_BIT_LATCH_ONLY];
  assign pre_tick = (s_q.pre == `CRT_PRE_LAST);
  assign t2_tick = s_q.mode[`CRT_BIT_T2_SRC] ? 1'b1 : t1_underflow;
  assign t3_tick = s_q.mode[`CRT_BIT_T3_SRC] ? pre_tick : t1_underflow;
  assign pulse_mode = s_q.mode[`CRT_BIT_OUT_EN] && s_q.mode[`CRT_BIT_OUT_SRC];
  assign t2_nx = crt_step(s_q.t2_cnt, s_q.t2_lat, t2_tick);
  assign t3_nx = crt_step(s_q.t3_cnt, s_q.t3_lat, t3_tick);

  // next state of the whole block
  always_comb
  begin
    s_d = s_q;
    s_d.pre = s_q.pre + 3'h1; // free-running clock/8 prescaler
    if (wr_mode)
      s_d.mode = reg_wdata; // latches are not touched here
    // timer two: a counter write overrides a same-cycle decrement
    s_d.t2_uf = t2_nx[8];
    s_d.t2_cnt = t2_nx[7:0];
    if (wr_t2)
    begin
      s_d.t2_lat = reg_wdata;
      if (!latch_only)
        s_d.t2_cnt = reg_wdata;
      else if (t2_nx[8])
        s_d.t2_cnt = reg_wdata; // new latch value reloads at this underflow
    end
    // timer three ignores the write-control bit
    s_d.t3_uf = t3_nx[8];
    s_d.t3_cnt = t3_nx[7:0];
    if (wr_t3)
    begin
      s_d.t3_lat = reg_wdata;
      s_d.t3_cnt = reg_wdata;
    end
    // pulse level rests at the start level of the incoming mode, so one write
    // that turns pulse mode on and flips polarity still starts at the new level
    if (!pulse_mode)
      s_d.pulse_lvl = ~s_d.mode[`CRT_BIT_POL];
    else if (t2_nx[8])
      s_d.pulse_lvl = ~s_q.pulse_lvl;
    // pin registered so the output comes from a flop; idle low when off
    s_d.pin_oe = s_q.mode[`CRT_BIT_OUT_EN];
    if (!s_q.mode[`CRT_BIT_OUT_EN])
      s_d.pin = 1'b0;
    else if (s_q.mode[`CRT_BIT_OUT_SRC])
      s_d.pin = s_q.pulse_lvl;
    else
      s_d.pin = t1_out_level;
    // sticky requests: setting beats a same-cycle clear
    if (wr_clr)
      s_d.stat = s_q.stat & ~reg_wdata[1:0];
    if (t2_nx[8])
      s_d.stat[`CRT_IRQ_T2] = 1'b1;
    if (t3_nx[8])
      s_d.stat[`CRT_IRQ_T3] = 1'b1;
    if (wr_en)
      s_d.en = reg_wdata[1:0];
    s_d.irq = |(s_d.stat & s_d.en);
    // read data stand in the cycle after the strobe only
    s_d.rdata = `CRT_ZERO8;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `CRT_ADDR_MODE: s_d.rdata = s_q.mode;
        `CRT_ADDR_T2: s_d.rdata = s_q.t2_cnt;
        `CRT_ADDR_T3: s_d.rdata = s_q.t3_cnt;
        `CRT_ADDR_STAT: s_d.rdata = {6'h00, s_q.stat};
        `CRT_ADDR_EN: s_d.rdata = {6'h00, s_q.en};
        default: s_d.rdata = `CRT_ZERO8; // clear register and holes read zero
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s_q <= '0;
      s_q.mode <= `CRT_MODE_RST;
      s_q.t2_cnt <= `CRT_CNT_RST;
      s_q.t2_lat <= `CRT_CNT_RST;
      s_q.t3_cnt <= `CRT_CNT_RST;
      s_q.t3_lat <= `CRT_CNT_RST;
      s_q.pre <= `CRT_PRE_RST;
      s_q.stat <= `CRT_IRQ_RST;
      s_q.en <= `CRT_IRQ_RST;
      s_q.pulse_lvl <= `CRT_LVL_RST;
    end
    else
      s_q <= s_d;
  end

  // outputs straight from the state flops
  assign reg_rdata = s_q.rdata;
  assign timer_pulse_pin = s_q.pin;
  assign timer_pulse_pin_oe = s_q.pin_oe;
  assign t2_underflow = s_q.t2_uf;
  assign t3_underflow = s_q.t3_uf;
  assign irq = s_q.irq;

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  property p_latch_only_write;
    wr_t2 && latch_only && !t2_nx[8] |=> (s_q.t2_lat == $past(reg_wdata)) && (s_q.t2_cnt == $past(t2_nx[7:0]));
  endproperty
  a_latch_only_write: assert property (p_latch_only_write) else $error("latch-only write changed counter");

  property p_full_write;
    wr_t2 && !latch_only |=> (s_q.t2_cnt == $past(reg_wdata)) && (s_q.t2_lat == $past(reg_wdata));
  endproperty
  a_full_write: assert property (p_full_write) else $error("timer two write missed counter");

  property p_mode_reset;
    @(posedge core_clk) disable iff (1'b0) srst |=> (s_q.mode[`CRT_BIT_LATCH_ONLY] == 1'b0);
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("write-control bit not zero after reset");

  property p_latch_kept;
    !wr_t2 && !wr_t3 |=> (s_q.t2_lat == $past(s_q.t2_lat)) && (s_q.t3_lat == $past(s_q.t3_lat));
  endproperty
  a_latch_kept: assert property (p_latch_kept) else $error("reload latch changed without write");

  property p_t2_clock_count;
    s_q.mode[`CRT_BIT_T2_SRC] && !wr_t2 && s_q.t2_cnt != `CRT_ZERO8 |=> s_q.t2_cnt == $past(s_q.t2_cnt) - 8'h01;
  endproperty
  a_t2_clock_count: assert property (p_t2_clock_count) else $error("timer two missed clock decrement");

  property p_reload;
    t2_tick && !wr_t2 && s_q.t2_cnt == `CRT_ZERO8 |=> t2_underflow && s_q.t2_cnt == $past(s_q.t2_lat)
      && s_q.stat[`CRT_IRQ_T2];
  endproperty
  a_reload: assert property (p_reload) else $error("underflow did not reload and request");

  property p_toggle;
    pulse_mode && t2_nx[8] && $stable(s_q.mode) |=> s_q.pulse_lvl != $past(s_q.pulse_lvl);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pulse level did not invert");

  property p_start_level;
    !pulse_mode |=> s_q.pulse_lvl == !s_q.mode[`CRT_BIT_POL];
  endproperty
  a_start_level: assert property (p_start_level) else $error("pulse start level wrong");

  property p_t3_div8;
    s_q.mode[`CRT_BIT_T3_SRC] && !wr_t3 && !pre_tick |=> s_q.t3_cnt == $past(s_q.t3_cnt);
  endproperty
  a_t3_div8: assert property (p_t3_div8) else $error("timer three counted off the divided clock");

  property p_t3_write;
    wr_t3 |=> (s_q.t3_cnt == $past(reg_wdata)) && (s_q.t3_lat == $past(reg_wdata));
  endproperty
  a_t3_write: assert property (p_t3_write) else $error("timer three write missed counter or latch");

  property p_pin_idle;
    !s_q.mode[`CRT_BIT_OUT_EN] |=> !timer_pulse_pin_oe ##0 !timer_pulse_pin;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("pin driven while disabled");

  // timer two holds while no timer 1 underflow arrives
  property p_t2_hold_t1;
    !s_q.mode[`CRT_BIT_T2_SRC] && !t1_underflow && !wr_t2 |=> s_q.t2_cnt == $past(s_q.t2_cnt);
  endproperty
  a_t2_hold_t1: assert property (p_t2_hold_t1) else $error("timer two moved without a timer 1 underflow");

  // each timer 1 underflow takes exactly one off timer two
  property p_t2_t1_count;
    !s_q.mode[`CRT_BIT_T2_SRC] && t1_underflow && !wr_t2 && s_q.t2_cnt != `CRT_ZERO8
      |=> s_q.t2_cnt == $past(s_q.t2_cnt) - 8'h01;
  endproperty
  a_t2_t1_count: assert property (p_t2_t1_count) else $error("timer two missed an underflow decrement");

  // latch-only write on the underflow cycle reloads the new value at once
  property p_latch_only_uf;
    wr_t2 && latch_only && t2_nx[8] |=> (s_q.t2_cnt == $past(reg_wdata)) && (s_q.t2_lat == $past(reg_wdata));
  endproperty
  a_latch_only_uf: assert property (p_latch_only_uf) else $error("latch value not taken at underflow");

  // timer three reload and request at its own underflow
  property p_t3_reload;
    t3_tick && !wr_t3 && s_q.t3_cnt == `CRT_ZERO8 |=> t3_underflow && s_q.t3_cnt == $past(s_q.t3_lat)
      && s_q.stat[`CRT_IRQ_T3];
  endproperty
  a_t3_reload: assert property (p_t3_reload) else $error("timer three did not reload and request");

  // timer three holds while no timer 1 underflow arrives
  property p_t3_hold_t1;
    !s_q.mode[`CRT_BIT_T3_SRC] && !t1_underflow && !wr_t3 |=> s_q.t3_cnt == $past(s_q.t3_cnt);
  endproperty
  a_t3_hold_t1: assert property (p_t3_hold_t1) else $error("timer three moved without a timer 1 underflow");

  // timer three takes one off on each divided tick
  property p_t3_div_count;
    s_q.mode[`CRT_BIT_T3_SRC] && pre_tick && !wr_t3 && s_q.t3_cnt != `CRT_ZERO8
      |=> s_q.t3_cnt == $past(s_q.t3_cnt) - 8'h01;
  endproperty
  a_t3_div_count: assert property (p_t3_div_count) else $error("timer three missed a divided tick");

  // divided tick comes once in every eight cycles
  property p_pre_period;
    pre_tick |=> !pre_tick [*7] ##1 pre_tick;
  endproperty
  a_pre_period: assert property (p_pre_period) else $error("divided tick period is not eight");

  // in pulse mode the pin carries the pulse level
  property p_pulse_pin;
    pulse_mode |=> (timer_pulse_pin == $past(s_q.pulse_lvl)) && timer_pulse_pin_oe;
  endproperty
  a_pulse_pin: assert property (p_pulse_pin) else $error("pin does not carry pulse level");

  // with source zero the pin follows the timer 1 output
  property p_t1_pin;
    s_q.mode[`CRT_BIT_OUT_EN] && !s_q.mode[`CRT_BIT_OUT_SRC]
      |=> (timer_pulse_pin == $past(t1_out_level)) && timer_pulse_pin_oe;
  endproperty
  a_t1_pin: assert property (p_t1_pin) else $error("pin does not follow timer 1 output");

  // level only moves on an underflow, which keeps the duty at one half
  property p_level_held;
    pulse_mode && !t2_nx[8] |=> s_q.pulse_lvl == $past(s_q.pulse_lvl);
  endproperty
  a_level_held: assert property (p_level_held) else $error("pulse level moved without underflow");

  // a request stays until software clears it
  property p_stat_sticky;
    s_q.stat[`CRT_IRQ_T2] && !wr_clr |=> s_q.stat[`CRT_IRQ_T2];
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("timer two request lost");

  // an underflow beats a clear in the same cycle
  property p_set_wins;
    t3_nx[8] && wr_clr |=> s_q.stat[`CRT_IRQ_T3];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle request");

  // reading timer two returns its counter
  property p_read_t2;
    reg_rd && (reg_addr == `CRT_ADDR_T2) |=> reg_rdata == $past(s_q.t2_cnt);
  endproperty
  a_read_t2: assert property (p_read_t2) else $error("timer two read wrong");

  // reading timer three returns its counter
  property p_read_t3;
    reg_rd && (reg_addr == `CRT_ADDR_T3) |=> reg_rdata == $past(s_q.t3_cnt);
  endproperty
  a_read_t3: assert property (p_read_t3) else $error("timer three read wrong");

  // a mode write never disturbs either reload latch
  property p_mode_write;
    wr_mode |=> (s_q.t2_lat == $past(s_q.t2_lat)) && (s_q.t3_lat == $past(s_q.t3_lat));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write changed a reload latch");

  c_t2_reload: cover property (t2_underflow);
  c_t3_reload: cover property (t3_underflow);
  c_pulse_toggle: cover property (pulse_mode && t2_nx[8]);
  c_latch_only: cover property (wr_t2 && latch_only);
  c_pulse_low_start: cover property (!pulse_mode ##1 (pulse_mode && !s_q.pulse_lvl));

endmodule
`default_nettype wire

// file: test_cascaded_reload_timers_two_three.sv
// bench for the timer 2/3 block: a cycle model is compared with every output
// assumes crt_pkg and crt_defines.svh are compiled first
`timescale 1ns/10ps
`default_nettype none
module test_cascaded_reload_timers_two_three;
  import crt_pkg::*;
  logic core_clk, srst, reg_wr, reg_rd, t1u, t1l, on;
  crt_addr_t reg_addr;
  crt_byte_t reg_wdata, lf;
  logic [7:0] rdata;
  logic pin, oe, uf2, uf3, irq;
  int fails, cmp_count, m, c2, l2, c3, l3, pre, st, en, lv, e_rd, e_u2, e_u3, e_irq, p_a, o_a, pm, t2, t3;
  crt_byte_t pmode [8] = '{8'h09, 8'h41, 8'h49, 8'h69, 8'h09, 8'h61, 8'hC9, 8'hE9};
  crt_timers dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(rdata), .t1_underflow(t1u), .t1_out_level(t1l), .timer_pulse_pin(pin),
    .timer_pulse_pin_oe(oe), .t2_underflow(uf2), .t3_underflow(uf3), .irq(irq));
  function automatic crt_byte_t nx(input crt_byte_t v);
    nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (e !== g)
    begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // a gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input crt_addr_t a, input crt_byte_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input crt_addr_t a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wait_uf();
    int k;
    for (k = 0; k < 600 && uf2 !== 1'b1; k++)
      @(posedge core_clk);
    if (k == 600)
    begin
      fails++;
      stop_test();
    end
  endtask
  // reference model, sees the same pre-edge inputs as the design
  always @(posedge core_clk)
  begin
    p_a = m[6] ? (m[0] ? lv : t1l) : 0;
    o_a = m[6];
    pm = m[6] && m[0];
    e_rd = !reg_rd ? 0 : reg_addr == 0 ? m : reg_addr == 1 ? c2 : reg_addr == 2 ? c3 : reg_addr == 3 ? st :
      reg_addr == 5 ? en : 0;
    t2 = m[3] ? 1 : t1u;
    t3 = m[4] ? pre == 7 : t1u;
    pre = (pre + 1) % 8;
    e_u2 = t2 && c2 == 0;
    e_u3 = t3 && c3 == 0;
    if (t2)
      c2 = e_u2 ? l2 : c2 - 1;
    if (t3)
      c3 = e_u3 ? l3 : c3 - 1;
    if (pm && e_u2)
      lv = !lv;
    if (reg_wr)
      case (reg_addr)
        0: m = reg_wdata;
        1: l2 = reg_wdata;
        2: l3 = reg_wdata;
        4: st = st & ~reg_wdata[1:0];
        5: en = reg_wdata[1:0];
      endcase
    if (reg_wr && reg_addr == 1 && (!m[7] || e_u2))
      c2 = reg_wdata;
    if (reg_wr && reg_addr == 2)
      c3 = reg_wdata;
    st = st | e_u2 | (e_u3 << 1);
    // outside pulse mode the level rests at the start level of the mode just written
    if (!pm)
      lv = !m[5];
    if (srst)
    begin
      {m, st, en, pre, e_rd, e_u2, e_u3, p_a, o_a} = '0;
      {c2, l2, c3, l3, lv} = {{4{32'hFF}}, 32'h1};
    end
    e_irq = (st & en) != 0;
  end
  // outputs settle long before the falling edge, where all six are compared
  always @(negedge core_clk)
    if (on)
    begin
      chk("reg_rdata", e_rd, rdata);
      chk("t2_underflow", e_u2, uf2);
      chk("t3_underflow", e_u3, uf3);
      chk("irq", e_irq, irq);
      chk("pin", p_a, pin);
      chk("pin_oe", o_a, oe);
    end
  // random timer 1 pulses, never two in a row
  always @(posedge core_clk)
  begin
    lf <= nx(lf);
    t1u <= !t1u && lf[0];
    t1l <= lf[1];
  end
  initial
  begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial
  begin
    {reg_wr, reg_rd, t1u, t1l, on, fails, cmp_count} = '0;
    {reg_addr, reg_wdata} = '0;
    lf = 8'h0B;
    srst = 1;
    repeat (3) @(posedge core_clk);
    on = 1;
    srst <= 0;
    for (int a = 0; a < 8; a++)
      rd(crt_addr_t'(a));
    $display("test reset values done");
    wr(3'h5, 8'h03);
    wr(3'h0, 8'h08);
    wr(3'h1, 8'h02);
    wait_uf();
    rd(3'h1);
    rd(3'h3);
    wr(3'h4, 8'h01);
    $display("test direct load done");
    wr(3'h0, 8'h88);
    wr(3'h1, 8'h30);
    rd(3'h1);
    wait_uf();
    rd(3'h1);
    wr(3'h0, 8'h80);
    wr(3'h1, 8'h04);
    repeat (30) @(posedge core_clk);
    $display("test latch only done");
    wr(3'h0, 8'h90);
    wr(3'h2, 8'h03);
    repeat (80) @(posedge core_clk);
    rd(3'h2);
    rd(3'h3);
    wr(3'h0, 8'h80);
    wr(3'h2, 8'h01);
    repeat (60) @(posedge core_clk);
    $display("test timer three done");
    foreach (pmode[i])
    begin
      wr(3'h0, pmode[i]);
      wr(3'h1, 8'h03);
      repeat (40) @(posedge core_clk);
    end
    $display("test pulse output done");
    repeat (150)
    begin
      if (lf[3])
        wr(lf[2:0], nx(lf));
      else
        rd(lf[2:0]);
    end
    $display("test random traffic done");
    srst <= 1;
    repeat (2) @(posedge core_clk);
    srst <= 0;
    for (int a = 0; a < 8; a++)
      rd(crt_addr_t'(a));
    $display("test second reset done");
    stop_test();
  end
endmodule
`default_nettype wire
